// *** core/status_pkg.sv ***
// Shared types and constants of the status and error reporting block.
// Assumes one 250 MHz clock and a synchronous, active-high reset.
package status_pkg;
  localparam logic [15:0] ENAB_RST    = 16'h0000;
  localparam logic [15:0] ENAB_LEGAL  = 16'h7FFF;
  localparam logic [15:0] QUES_IMPL   = 16'h0301;
  localparam logic [15:0] COND_ANSWER = 16'h0000;
  localparam int          SUM_BIT     = 3;
  localparam logic [15:0] VERSION_X10 = 16'h4DC6;
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_UNDEF   = 16'hFF8F;
  localparam logic [15:0] ERR_MACRO   = 16'hFEF2;
  localparam logic [15:0] ERR_OVFL    = 16'hFEA2;
  localparam logic [3:0]  QUEUE_DEPTH = 4'hF;
  localparam int          MACRO_SLOTS = 4;

  typedef enum logic [3:0] {
    CMD_QCOND   = 4'h0, CMD_QENAB_WR = 4'h1, CMD_QENAB_RD = 4'h2,
    CMD_QEVEN   = 4'h3, CMD_ERR_RD   = 4'h4, CMD_CLS      = 4'h5,
    CMD_RST     = 4'h6, CMD_PURGE    = 4'h7, CMD_MACRO    = 4'h8,
    CMD_VERSION = 4'h9, CMD_REF_ON   = 4'hA, CMD_REF_OFF  = 4'hB
  } cmd_code_t;

  typedef enum logic [2:0] {
    MSG_NO_ERROR = 3'h0, MSG_UNDEF_HEADER = 3'h1, MSG_MACRO_ERROR = 3'h2,
    MSG_TOO_MANY = 3'h3, MSG_OTHER = 3'h4
  } msg_t;

  typedef struct packed {
    logic [3:0]  code;
    logic [15:0] arg;
  } cmd_t;

  typedef struct packed {
    logic [15:0] num;
    msg_t        msg;
  } err_entry_t;

  typedef struct packed {
    logic [15:0] num;
    msg_t        msg;
    logic [15:0] value;
  } rsp_t;
endpackage

// *** core/ques_event_latch.sv ***
// Questionable event latch: rising edges of condition bits, clear on read.
// Assumes the condition word is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module ques_event_latch
  import status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] cond,
  input  wire logic        clr,
  output logic      [15:0] event_q
);
  logic [15:0] prev_q;
  logic [15:0] prev_d;
  logic [15:0] event_d;

  always_comb begin
    prev_d  = cond & QUES_IMPL;
    // A rise in the clearing cycle survives the clear
    event_d = (clr ? 16'h0000 : event_q) | (prev_d & ~prev_q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q  <= 16'h0000;
      event_q <= 16'h0000;
    end else begin
      prev_q  <= prev_d;
      event_q <= event_d;
    end
  end
endmodule // ques_event_latch
`default_nettype wire

// *** core/error_queue.sv ***
// First-in first-out error queue of fifteen entries with overflow marker.
// Assumes the caller pops only when not empty.
`timescale 1ns/10ps
`default_nettype none
module error_queue
  import status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       push,
  input  wire err_entry_t push_entry,
  input  wire logic       pop,
  input  wire logic       clear,
  output err_entry_t      head,
  output logic [3:0]      count_q
);
  err_entry_t mem_q [16];
  logic [3:0] rd_q, wr_q, rd_d, wr_d, count_d;
  logic       full_q, full_d, do_write;
  logic [3:0] waddr;
  err_entry_t wdata;

  always_comb begin
    rd_d     = rd_q;
    wr_d     = wr_q;
    count_d  = count_q;
    full_d   = full_q;
    do_write = 1'b0;
    waddr    = wr_q;
    wdata    = push_entry;
    if (clear) begin
      rd_d    = wr_q;
      count_d = 4'h0;
      full_d  = 1'b0;
    end else begin
      if (pop) begin
        rd_d    = rd_q + 4'h1;
        count_d = count_q - 4'h1;
        full_d  = 1'b0;
      end
      if (push && (pop || count_q != QUEUE_DEPTH)) begin
        do_write = 1'b1;
        wr_d     = wr_q + 4'h1;
        count_d  = count_d + 4'h1;
      end else if (push && !full_q) begin
        do_write = 1'b1;
        waddr    = wr_q - 4'h1;
        wdata    = err_entry_t'{num: ERR_OVFL, msg: MSG_TOO_MANY};
        full_d   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q    <= 4'h0;
      wr_q    <= 4'h0;
      count_q <= 4'h0;
      full_q  <= 1'b0;
    end else begin
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      count_q <= count_d;
      full_q  <= full_d;
    end
  end

  always_ff @(posedge clk) begin
    if (do_write) begin
      mem_q[waddr] <= wdata;
    end
  end

  assign head = mem_q[rd_q];
endmodule // error_queue
`default_nettype wire

// *** core/status_error_reporting.sv ***
// Status reporting: questionable group, error queue, macros, indicators.
// Assumes one command per cycle on cmd_valid; answers come one cycle later.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Condition query always answers zero
// - Enable mask holds 0..32767, resets 0
// - Enabled latched event drives status bit 3
// - Enable query returns stored mask value
// - Event bits latch on rising condition only
// - Event read returns value then clears
// - Detected errors are pushed into queue
// - Error query pops oldest entry first
// - Empty queue query answers zero, no error
// - Clear status empties error queue
// - Fifteen entries; overflow overwrites newest with -350
// - After overflow reject errors until room
// - Queue starts empty after power-up
// - Instrument reset leaves error queue alone
// - Purge deletes named macro, else -270
// - Version query returns 1991.0
// - Reset or off command stops reference output
// - Remote indicator lights while addressed
// - Listen indicator lights while receiving
// - Talk indicator lights while sending
// - Service indicator lights while request pending
// - Gate indicator follows measurement gate
// - Only condition bits 0, 8, 9 exist
// - Clear status clears events, keeps masks
module status_error_reporting
  import status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire cmd_t        cmd,
  output rsp_t             rsp,
  output logic             rsp_valid,
  input  wire logic [15:0] questionable_condition,
  input  wire logic        err_valid,
  input  wire err_entry_t  err_in,
  output logic             err_ready,
  output logic [7:0]       status_byte,
  output logic             ref_out_en,
  input  wire logic        addressed,
  input  wire logic        listening,
  input  wire logic        talking,
  input  wire logic        srq_pending,
  input  wire logic        gate_open,
  input  wire logic        active,
  output logic             remote_indicator,
  output logic             listen_indicator,
  output logic             talk_indicator,
  output logic             srq_indicator,
  output logic             gate_indicator,
  output logic             active_indicator
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic        is_cmd;
  cmd_code_t   code;
  logic        known;
  logic [15:0] ques_event;
  logic [15:0] enab_q, enab_d;
  logic        ev_clr;
  err_entry_t  q_head;
  logic [3:0]  q_count;
  logic        q_empty;
  logic        q_pop;
  logic        q_push;
  err_entry_t  q_entry;
  logic        int_err;
  err_entry_t  int_entry;

  assign code    = cmd_code_t'(cmd.code);
  assign known   = cmd.code <= CMD_REF_OFF;
  assign is_cmd  = cmd_valid && known;
  assign q_empty = q_count == 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Questionable group

  ques_event_latch u_latch (
    .clk     (clk),
    .rst     (rst),
    .cond    (questionable_condition),
    .clr     (ev_clr),
    .event_q (ques_event)
  );

  assign ev_clr = is_cmd && (code == CMD_QEVEN || code == CMD_CLS);

  always_comb begin
    enab_d = enab_q;
    if (is_cmd && code == CMD_QENAB_WR) begin
      enab_d = cmd.arg & ENAB_LEGAL;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enab_q <= ENAB_RST;
    end else begin
      enab_q <= enab_d;
    end
  end

  // Summary is live so it drops in the same cycle the event is read away
  always_comb begin
    status_byte          = 8'h00;
    status_byte[SUM_BIT] = |(ques_event & enab_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Macro table

  logic [7:0]             mname_q [MACRO_SLOTS];
  logic [MACRO_SLOTS-1:0] mvalid_q, mvalid_d;
  logic [7:0]             mname_new;
  logic [1:0]             mslot;
  logic                   mwrite;

  function automatic logic [2:0] find_slot(input logic [7:0] name,
                                           input logic       want_free);
    logic [2:0] hit;
    hit = 3'h4;
    for (int i = MACRO_SLOTS - 1; i >= 0; i--) begin
      if (want_free ? !mvalid_q[i] : (mvalid_q[i] && mname_q[i] == name)) begin
        hit = 3'(i);
      end
    end
    return hit;
  endfunction

  always_comb begin
    logic [2:0] same;
    logic [2:0] free;
    same      = find_slot(cmd.arg[7:0], 1'b0);
    free      = find_slot(cmd.arg[7:0], 1'b1);
    mvalid_d  = mvalid_q;
    mname_new = cmd.arg[7:0];
    mslot     = 2'h0;
    mwrite    = 1'b0;
    int_err   = 1'b0;
    int_entry = '{num: ERR_NONE, msg: MSG_NO_ERROR};
    if (cmd_valid && !known) begin
      int_err   = 1'b1;
      int_entry = '{num: ERR_UNDEF, msg: MSG_UNDEF_HEADER};
    end else if (is_cmd && code == CMD_PURGE) begin
      if (same[2]) begin
        int_err   = 1'b1;
        int_entry = '{num: ERR_MACRO, msg: MSG_MACRO_ERROR};
      end else begin
        mvalid_d[same[1:0]] = 1'b0;
      end
    end else if (is_cmd && code == CMD_MACRO) begin
      // A full table is reported the same way as a bad purge
      if (!same[2]) begin
        mslot  = same[1:0];
        mwrite = 1'b1;
      end else if (!free[2]) begin
        mslot  = free[1:0];
        mwrite = 1'b1;
        mvalid_d[free[1:0]] = 1'b1;
      end else begin
        int_err   = 1'b1;
        int_entry = '{num: ERR_MACRO, msg: MSG_MACRO_ERROR};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mvalid_q <= '0;
    end else begin
      mvalid_q <= mvalid_d;
    end
  end

  always_ff @(posedge clk) begin
    if (mwrite) begin
      mname_q[mslot] <= mname_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error queue

  // Internal errors take the single write port; outside errors wait
  assign err_ready = !int_err;
  assign q_push    = int_err || err_valid;
  assign q_entry   = int_err ? int_entry : err_in;
  assign q_pop     = is_cmd && code == CMD_ERR_RD && !q_empty;

  error_queue u_queue (
    .clk        (clk),
    .rst        (rst),
    .push       (q_push),
    .push_entry (q_entry),
    .pop        (q_pop),
    .clear      (is_cmd && code == CMD_CLS),
    .head       (q_head),
    .count_q    (q_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answers, reference output and indicators

  rsp_t rsp_d;
  logic rsp_valid_d;
  logic ref_d;
  logic [5:0] led_d, led_q;

  always_comb begin
    rsp_d       = '{num: ERR_NONE, msg: MSG_NO_ERROR, value: 16'h0000};
    rsp_valid_d = 1'b0;
    if (is_cmd) begin
      unique case (code)
        CMD_QCOND: begin
          rsp_valid_d = 1'b1;
          rsp_d.value = COND_ANSWER;
        end
        CMD_QENAB_RD: begin
          rsp_valid_d = 1'b1;
          rsp_d.value = enab_q;
        end
        CMD_QEVEN: begin
          rsp_valid_d = 1'b1;
          rsp_d.value = ques_event;
        end
        CMD_ERR_RD: begin
          rsp_valid_d = 1'b1;
          if (!q_empty) begin
            rsp_d.num = q_head.num;
            rsp_d.msg = q_head.msg;
          end
        end
        CMD_VERSION: begin
          rsp_valid_d = 1'b1;
          rsp_d.value = VERSION_X10;
        end
        CMD_QENAB_WR, CMD_CLS, CMD_RST, CMD_PURGE,
        CMD_MACRO, CMD_REF_ON, CMD_REF_OFF: begin
          rsp_valid_d = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    ref_d = ref_out_en;
    if (is_cmd && code == CMD_REF_ON) begin
      ref_d = 1'b1;
    end
    if (is_cmd && (code == CMD_REF_OFF || code == CMD_RST)) begin
      ref_d = 1'b0;
    end
    led_d = {active, gate_open, srq_pending, talking, listening, addressed};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp       <= '{num: ERR_NONE, msg: MSG_NO_ERROR, value: 16'h0000};
      rsp_valid <= 1'b0;
      ref_out_en <= 1'b0;
      led_q     <= 6'h00;
    end else begin
      rsp       <= rsp_d;
      rsp_valid <= rsp_valid_d;
      ref_out_en <= ref_d;
      led_q     <= led_d;
    end
  end

  // One flop of lag on every lamp keeps their durations exact
  assign remote_indicator = led_q[0];
  assign listen_indicator = led_q[1];
  assign talk_indicator   = led_q[2];
  assign srq_indicator    = led_q[3];
  assign gate_indicator   = led_q[4];
  assign active_indicator = led_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_cond_zero;
    @(posedge clk) disable iff (rst)
    is_cmd && code == CMD_QCOND |=> rsp_valid && rsp.value == 16'h0000;
  endproperty
  a_cond_zero: assert property (p_cond_zero) else $error("condition query not zero");

  property p_enab_range;
    @(posedge clk) disable iff (rst) !enab_q[15];
  endproperty
  a_enab_range: assert property (p_enab_range) else $error("mask above 32767");

  property p_summary;
    @(posedge clk) disable iff (rst)
    $rose(questionable_condition[8]) && enab_q[8] |=> status_byte[3];
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit missing");

  property p_latch;
    @(posedge clk) disable iff (rst) $rose(questionable_condition[9]) |=> ques_event[9];
  endproperty
  a_latch: assert property (p_latch) else $error("event did not latch");

  property p_no_fake;
    @(posedge clk) disable iff (rst)
    questionable_condition[1] |-> ##1 !ques_event[1];
  endproperty
  a_no_fake: assert property (p_no_fake) else $error("unimplemented bit set");

  property p_ev_clear;
    @(posedge clk) disable iff (rst)
    is_cmd && code == CMD_QEVEN && (questionable_condition & QUES_IMPL) == 16'h0000
    ##1 (questionable_condition & QUES_IMPL) == 16'h0000 |-> ques_event == 16'h0000;
  endproperty
  a_ev_clear: assert property (p_ev_clear) else $error("event not cleared");

  property p_empty_ans;
    @(posedge clk) disable iff (rst)
    is_cmd && code == CMD_ERR_RD && q_empty |=> rsp_valid && rsp.num == 16'h0000;
  endproperty
  a_empty_ans: assert property (p_empty_ans) else $error("empty answer wrong");

  property p_cls;
    @(posedge clk) disable iff (rst)
    is_cmd && code == CMD_CLS && !q_push |=> q_count == 4'h0 && enab_q == $past(enab_q);
  endproperty
  a_cls: assert property (p_cls) else $error("clear status wrong");

  property p_cap;
    @(posedge clk) disable iff (rst)
    q_count == QUEUE_DEPTH && q_push && !q_pop && !(is_cmd && code == CMD_CLS)
    |=> q_count == QUEUE_DEPTH;
  endproperty
  a_cap: assert property (p_cap) else $error("queue above fifteen");

  property p_rst_keep;
    @(posedge clk) disable iff (rst)
    is_cmd && code == CMD_RST && !q_push |=> q_count == $past(q_count);
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("reset changed queue");

  property p_ref_off;
    @(posedge clk) disable iff (rst) is_cmd && code == CMD_RST |=> !ref_out_en;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference still on");

  property p_gate;
    @(posedge clk) disable iff (rst) gate_open ##1 gate_open |-> gate_indicator;
  endproperty
  a_gate: assert property (p_gate) else $error("gate lamp wrong");

  c_overflow: cover property (@(posedge clk) q_count == 4'hF && q_push && !q_pop);
  c_purge_err: cover property (@(posedge clk) int_err && int_entry.num == ERR_MACRO);
  c_ev_read: cover property (@(posedge clk) ev_clr && ques_event != 16'h0000);
endmodule // status_error_reporting
`default_nettype wire

// *** dv/host_model.sv ***
// Host computer model: issues one command at a time on the command port.
// Assumes the block answers one cycle after it takes a query.
`timescale 1ns/10ps
`default_nettype none
module host_model
  import status_pkg::*;
(
  input  wire logic clk,
  output logic      cmd_valid,
  output cmd_t      cmd,
  input  wire rsp_t rsp,
  input  wire logic rsp_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive on the falling edge; the answer pulse stands for one cycle only,
  // so it is sampled at the next falling edge before anything is released.
  task automatic issue(input logic [3:0] code, input logic [15:0] arg,
                       output rsp_t r, output logic got);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd       = {code, (code == CMD_QENAB_WR) ? (arg & ENAB_LEGAL) : arg};
    @(negedge clk);
    got       = rsp_valid;
    r         = rsp;
    cmd_valid = 1'b0;
    // Released lines do not keep the last value
    cmd       = ~cmd;
  endtask
endmodule // host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench of the status and error reporting block.
// Assumes the host model drives commands; the bench drives all other inputs.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
  import status_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid;
  cmd_t       cmd;
  rsp_t       rsp;
  logic       rsp_valid;
  logic [15:0] questionable_condition = 16'h0000;
  logic       err_valid = 1'b0;
  err_entry_t err_in = '0;
  logic       err_ready;
  logic [7:0] status_byte;
  logic       ref_out_en;
  logic [5:0] lamps = 6'h00;
  logic [5:0] ind;
  rsp_t       r;
  logic       got;
  int         n_errors = 0;
  int         samples_checked = 0;

  always #2 clk = ~clk;

  host_model u_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp),
    .rsp_valid(rsp_valid));

  status_error_reporting u_status_error_reporting (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .rsp_valid(rsp_valid),
    .questionable_condition(questionable_condition), .err_valid(err_valid), .err_in(err_in),
    .err_ready(err_ready), .status_byte(status_byte), .ref_out_en(ref_out_en),
    .addressed(lamps[5]), .listening(lamps[4]), .talking(lamps[3]),
    .srq_pending(lamps[2]), .gate_open(lamps[1]), .active(lamps[0]),
    .remote_indicator(ind[5]), .listen_indicator(ind[4]), .talk_indicator(ind[3]),
    .srq_indicator(ind[2]), .gate_indicator(ind[1]), .active_indicator(ind[0]));

  ////////////////////////////////////////////////////////////////////////////
  task automatic ask(input logic [3:0] c, input logic [15:0] a);
    u_host_model.issue(c, a, r, got);
  endtask

  // An internal error may take the push port, so wait for ready (bounded)
  task automatic push(input logic [15:0] n);
    @(negedge clk);
    err_valid = 1'b1;
    err_in    = {n, MSG_OTHER};
    for (int k = 0; k < 4 && err_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    err_valid = 1'b0;
    err_in    = ~err_in;
  endtask

  task automatic pop_chk(input logic [15:0] n);
    ask(CMD_ERR_RD, 16'h0000);
    `CHK({got, r.num}, {1'b1, n})
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    ask(CMD_QENAB_RD, 16'h0000);
    `CHK(r.value, ENAB_RST)
    `CHK(err_ready, 1'b1)
    ask(CMD_ERR_RD, 16'h0000);
    `CHK({got, r.num, r.msg}, {1'b1, ERR_NONE, MSG_NO_ERROR})
    $display("test reset done");
  endtask

  task automatic t_events();
    ask(CMD_QENAB_WR, 16'h0301);
    ask(CMD_QENAB_RD, 16'h0000);
    `CHK(r.value, 16'h0301)
    `CHK(status_byte, 8'h00)
    @(negedge clk);
    questionable_condition = 16'h0100;
    repeat (2) @(negedge clk);
    `CHK(status_byte, 8'h08)
    ask(CMD_QCOND, 16'h0000);
    `CHK({got, r.value}, {1'b1, COND_ANSWER})
    ask(CMD_QEVEN, 16'h0000);
    `CHK(r.value, 16'h0100)
    // Condition still high: a level must not latch again
    ask(CMD_QEVEN, 16'h0000);
    `CHK(r.value, 16'h0000)
    `CHK(status_byte, 8'h00)
    ask(CMD_QENAB_WR, 16'h7FFF);
    @(negedge clk);
    questionable_condition = 16'h0302;
    repeat (2) @(negedge clk);
    `CHK(status_byte, 8'h08)
    ask(CMD_CLS, 16'h0000);
    `CHK(status_byte, 8'h00)
    ask(CMD_QEVEN, 16'h0000);
    `CHK(r.value, 16'h0000)
    ask(CMD_QENAB_RD, 16'h0000);
    `CHK(r.value, 16'h7FFF)
    questionable_condition = 16'h0000;
    @(negedge clk);
    questionable_condition = 16'h0302;
    repeat (2) @(negedge clk);
    ask(CMD_QEVEN, 16'h0000);
    `CHK(r.value, 16'h0300)
    questionable_condition = 16'h0000;
    ask(CMD_QEVEN, 16'h0000);
    `CHK(r.value, 16'h0000)
    $display("test events done");
  endtask

  task automatic t_queue();
    for (int i = 1; i <= 3; i++) push(16'(16'h0011 * i));
    for (int i = 1; i <= 3; i++) pop_chk(16'(16'h0011 * i));
    pop_chk(ERR_NONE);
    $display("test queue done");
  endtask

  task automatic t_overflow();
    for (int i = 1; i <= 17; i++) push(16'(i));
    pop_chk(16'h0001);
    push(16'h00AA);
    for (int i = 2; i <= 14; i++) pop_chk(16'(i));
    ask(CMD_ERR_RD, 16'h0000);
    `CHK({r.num, r.msg}, {ERR_OVFL, MSG_TOO_MANY})
    pop_chk(16'h00AA);
    pop_chk(ERR_NONE);
    $display("test overflow done");
  endtask

  task automatic t_cls_rst();
    push(16'h0044);
    push(16'h0055);
    ask(CMD_REF_ON, 16'h0000);
    `CHK(ref_out_en, 1'b1)
    ask(CMD_RST, 16'h0000);
    `CHK(ref_out_en, 1'b0)
    pop_chk(16'h0044);
    ask(CMD_REF_ON, 16'h0000);
    ask(CMD_REF_OFF, 16'h0000);
    `CHK(ref_out_en, 1'b0)
    ask(CMD_CLS, 16'h0000);
    pop_chk(ERR_NONE);
    $display("test clear and reset done");
  endtask

  task automatic t_macro();
    ask(CMD_MACRO, 16'h0021);
    ask(CMD_PURGE, 16'h0021);
    // The failed purge takes the push port in the cycle it is presented
    fork
      ask(CMD_PURGE, 16'h0021);
      begin
        @(negedge clk);
        #1;
        `CHK(err_ready, 1'b0)
      end
    join
    ask(4'hC, 16'h0000);
    ask(CMD_ERR_RD, 16'h0000);
    `CHK({r.num, r.msg}, {ERR_MACRO, MSG_MACRO_ERROR})
    pop_chk(ERR_UNDEF);
    pop_chk(ERR_NONE);
    ask(CMD_VERSION, 16'h0000);
    `CHK({got, r.value}, {1'b1, VERSION_X10})
    $display("test macro and version done");
  endtask

  task automatic t_lamps();
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      lamps = 6'h01 << i;
      @(negedge clk);
      `CHK(ind, lamps)
    end
    lamps = 6'h00;
    $display("test indicators done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_events();
    t_queue();
    t_overflow();
    t_cls_rst();
    t_macro();
    t_lamps();
    conclude();
  end

  // Tests need well under a thousand cycles; this leaves wide margin
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
